// [src/smh_params.svh]
// Constants for the serial modem handshake control block: register
// offsets, field positions, reset values and timing counts.
// Assumes a 32-bit classic Wishbone slave with the registers in byte lane 0.
`ifndef SMH_PARAMS_SVH
`define SMH_PARAMS_SVH
`define SMH_ADR_MODE      8'h00
`define SMH_ADR_CFG       8'h04
`define SMH_ADR_CHANNEL_CONFIGURATION_TWO      8'h08
`define SMH_ADR_TRANSMIT_BYTE_COUNT_HIGH      8'h0C
`define SMH_ADR_ISR       8'h10
`define SMH_ADR_IMR       8'h14
`define SMH_ADR_STAT      8'h18
`define SMH_ADR_TXD       8'h1C
`define SMH_ADR_CMD       8'h20
`define SMH_ADR_RXD       8'h24
`define SMH_MODE_LOOP     0
`define SMH_MODE_SWC      1
`define SMH_MODE_SWL      2
`define SMH_MODE_RAC      3
`define SMH_CFG_PU        0
`define SMH_CFG_SM        2:1
`define SMH_CFG_BUS       3
`define SMH_CFG_CM        6:4
`define SMH_SM_ASYNC      2'h1
`define SMH_CHANNEL_CONFIGURATION_TWO_INV      0
`define SMH_CHANNEL_CONFIGURATION_TWO_SEL      7:6
`define SMH_TRANSMIT_BYTE_COUNT_HIGH_CAS      7
`define SMH_ISR_CTS       0
`define SMH_ISR_XMR       1
`define SMH_ISR_ALL_SENT_IRQ      2
`define SMH_ISR_XPR       3
`define SMH_CMD_XMIT      0
`define SMH_CMD_XRES      1
`define SMH_MODE_RST      8'h00
`define SMH_CFG_RST       8'h00
`define SMH_CHANNEL_CONFIGURATION_TWO_RST      8'h00
`define SMH_TRANSMIT_BYTE_COUNT_HIGH_RST      8'h00
`define SMH_IMR_RST       8'hFF
`define SMH_CLK_MHZ       100
`define SMH_RESET_MIN_US  5
`define SMH_RESET_CYCLES  (`SMH_RESET_MIN_US * `SMH_CLK_MHZ)
`define SMH_CLKS_PER_BIT  16
`endif

// [src/smh_pkg.sv]
// Types shared by the serial modem handshake control block.
// Assumes the constants header is included by each user.
package smh_pkg;
  typedef enum logic {SMH_TX_IDLE, SMH_TX_SHIFT} smh_tx_state_e;
  typedef enum logic {SMH_RX_IDLE, SMH_RX_SHIFT} smh_rx_state_e;
endpackage

// [src/smh_sync.sv]
// Two-flop synchroniser for a group of pin inputs.
// Assumes the bits are independent levels; no word coherence.
`timescale 1ns/1ps
`default_nettype none
module smh_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// [src/smh_tick.sv]
// Bit-rate divider producing a one-cycle enable pulse.
// Assumes CLKS is at least 2; the count restarts while run is low.
`timescale 1ns/1ps
`default_nettype none
module smh_tick #(
  parameter int CLKS = 16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Enable in, bit pulse out
  input  wire logic run,
  output logic      tick
);
  localparam int CW = $clog2(CLKS);
  localparam logic [CW-1:0] LAST = CW'(CLKS - 1);
  logic [CW-1:0] cnt;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (!run) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt == LAST);
      cnt  <= (cnt == LAST) ? '0 : cnt + 1'b1;
    end
  end
endmodule
`default_nettype wire

// [src/smh_modem_ctrl.sv]
// Modem handshake control of one serial channel with a classic Wishbone
// register slave, a small transmit buffer and a character shifter pair.
// Assumes one 100 MHz clock, pins synchronised here, and DEPTH a power
// of two so that the buffer pointers wrap naturally.
`timescale 1ns/1ps
`default_nettype none
`include "smh_params.svh"
module smh_modem_ctrl #(
  parameter int DEPTH        = 8,
  parameter int CLKS_PER_BIT = `SMH_CLKS_PER_BIT
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack,
  // Modem lines and serial data
  input  wire logic        cts_n,
  input  wire logic        cd,
  input  wire logic        rxd,
  output logic             txd,
  output logic             rts_n,
  output logic             irq_n
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] POOL = (AW+1)'(DEPTH / 2);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction

  logic [7:0]    mode_reg;
  logic [7:0]    channel_configuration_zero;
  logic [7:0]    channel_configuration_two;
  logic [7:0]    transmit_byte_count_high;
  logic [7:0]    second_interrupt_status;
  logic [7:0]    second_interrupt_mask;
  logic          cts_n_s;
  logic          cd_s;
  logic          rxd_s;
  logic          cts_prev;
  logic          bit_tick;
  logic [7:0]    mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] frm_ptr;
  logic [AW:0]   count;
  logic [AW:0]   sent;
  logic          start_kept;
  logic          frame_open;
  logic          tx_req;
  logic [9:0]    tx_shift;
  logic [3:0]    tx_bits;
  logic          tx_mark_d;
  logic          ev_xmr;
  logic          ev_all_sent_irq;
  logic          ev_xpr;
  logic [7:0]    rx_sh;
  logic [3:0]    rx_bits;
  logic [7:0]    rx_data;
  logic          rx_valid;
  logic          next_rts_n;
  smh_pkg::smh_tx_state_e tx_state;
  smh_pkg::smh_rx_state_e rx_state;

  smh_sync #(.W(3)) u_sync (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .d     ({cts_n, cd, rxd}),
    .q     ({cts_n_s, cd_s, rxd_s})
  );

  // Field views.
  logic       power_up;
  logic       loop_on;
  logic       frame_mode;
  logic       bus_cfg;
  logic [2:0] clk_mode;
  logic [1:0] rts_sel;
  logic       invert;
  logic       cts_ok;
  logic       tx_line;
  logic       rx_line;
  logic       cd_ctrl;
  logic       rx_allow;
  logic       rx_active;
  assign power_up   = channel_configuration_zero[`SMH_CFG_PU];
  assign loop_on    = mode_reg[`SMH_MODE_LOOP];
  assign frame_mode = channel_configuration_zero[`SMH_CFG_SM] != `SMH_SM_ASYNC;
  assign bus_cfg    = channel_configuration_zero[`SMH_CFG_BUS];
  assign clk_mode   = channel_configuration_zero[`SMH_CFG_CM];
  assign rts_sel    = channel_configuration_two[`SMH_CHANNEL_CONFIGURATION_TWO_SEL];
  assign invert     = channel_configuration_two[`SMH_CHANNEL_CONFIGURATION_TWO_INV];
  assign cts_ok     = !cts_n_s;
  assign tx_line    = tx_shift[0];
  assign rx_active  = rx_state == smh_pkg::SMH_RX_SHIFT;
  // Loopback takes the internal line, before inversion and the pin flop.
  assign rx_line    = loop_on ? tx_line : (rxd_s ^ invert);
  // Clock modes 1 and 5 have no carrier control.
  assign cd_ctrl    = transmit_byte_count_high[`SMH_TRANSMIT_BYTE_COUNT_HIGH_CAS] &&
                      clk_mode != 3'h1 && clk_mode != 3'h5;
  assign rx_allow   = power_up && mode_reg[`SMH_MODE_RAC] &&
                      (!cd_ctrl || cd_s);

  smh_tick #(.CLKS(CLKS_PER_BIT)) u_tick (
    .clk   (sys_clk),
    .rst_n (rst_n),
    .run   (power_up),
    .tick  (bit_tick)
  );

  // Wishbone strobes; a request is answered one cycle after it arrives.
  logic req;
  logic wr;
  logic rd;
  logic push;
  logic cmd_xmit;
  logic cmd_xres;
  logic [AW:0] held;
  logic [AW:0] cnt_push;
  assign req      = wb_cyc && wb_stb && !wb_ack;
  assign wr       = req && wb_we && wb_sel[0];
  assign rd       = req && !wb_we;
  assign held     = start_kept ? sent : '0;
  assign push     = wr && hit(wb_adr, `SMH_ADR_TXD) &&
                    (count + held < FULL);
  assign cmd_xmit = wr && hit(wb_adr, `SMH_ADR_CMD) &&
                    wb_dat_i[`SMH_CMD_XMIT];
  assign cmd_xres = wr && hit(wb_adr, `SMH_ADR_CMD) &&
                    wb_dat_i[`SMH_CMD_XRES];
  assign cnt_push = push ? count + 1'b1 : count;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack <= 1'b0;
    end else begin
      wb_ack <= req;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= '0;
    end else if (rd) begin
      wb_dat_o <= '0;
      if (hit(wb_adr, `SMH_ADR_MODE)) begin
        wb_dat_o[7:0] <= mode_reg;
      end else if (hit(wb_adr, `SMH_ADR_CFG)) begin
        wb_dat_o[7:0] <= channel_configuration_zero;
      end else if (hit(wb_adr, `SMH_ADR_CHANNEL_CONFIGURATION_TWO)) begin
        wb_dat_o[7:0] <= channel_configuration_two;
      end else if (hit(wb_adr, `SMH_ADR_TRANSMIT_BYTE_COUNT_HIGH)) begin
        wb_dat_o[7:0] <= transmit_byte_count_high;
      end else if (hit(wb_adr, `SMH_ADR_ISR)) begin
        wb_dat_o[7:0] <= second_interrupt_status;
      end else if (hit(wb_adr, `SMH_ADR_IMR)) begin
        wb_dat_o[7:0] <= second_interrupt_mask;
      end else if (hit(wb_adr, `SMH_ADR_STAT)) begin
        wb_dat_o[7:0] <= {1'b0, rx_valid, count + held >= FULL, rx_active,
                          tx_state == smh_pkg::SMH_TX_SHIFT, !rts_n,
                          cd_s, cts_ok};
      end else if (hit(wb_adr, `SMH_ADR_RXD)) begin
        wb_dat_o[7:0] <= rx_data;
      end
    end
  end

  // Control registers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg                   <= `SMH_MODE_RST;
      channel_configuration_zero <= `SMH_CFG_RST;
      channel_configuration_two  <= `SMH_CHANNEL_CONFIGURATION_TWO_RST;
      transmit_byte_count_high   <= `SMH_TRANSMIT_BYTE_COUNT_HIGH_RST;
      second_interrupt_mask      <= `SMH_IMR_RST;
    end else if (wr) begin
      if (hit(wb_adr, `SMH_ADR_MODE)) begin
        mode_reg <= wb_dat_i[7:0];
      end
      if (hit(wb_adr, `SMH_ADR_CFG)) begin
        channel_configuration_zero <= wb_dat_i[7:0];
      end
      if (hit(wb_adr, `SMH_ADR_CHANNEL_CONFIGURATION_TWO)) begin
        channel_configuration_two <= wb_dat_i[7:0];
      end
      if (hit(wb_adr, `SMH_ADR_TRANSMIT_BYTE_COUNT_HIGH)) begin
        transmit_byte_count_high <= wb_dat_i[7:0];
      end
      if (hit(wb_adr, `SMH_ADR_IMR)) begin
        second_interrupt_mask <= wb_dat_i[7:0];
      end
    end
  end

  // Sticky events; a new event outranks a write-one clear.
  logic [7:0] isr_set;
  logic [7:0] isr_clr;
  always_comb begin
    isr_set = '0;
    isr_set[`SMH_ISR_CTS]  = cts_n_s != cts_prev;
    isr_set[`SMH_ISR_XMR]  = ev_xmr;
    isr_set[`SMH_ISR_ALL_SENT_IRQ] = ev_all_sent_irq;
    isr_set[`SMH_ISR_XPR]  = ev_xpr;
    isr_clr = (wr && hit(wb_adr, `SMH_ADR_ISR)) ? wb_dat_i[7:0] : '0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      second_interrupt_status <= '0;
      cts_prev                <= 1'b1;
      irq_n                   <= 1'b1;
    end else begin
      cts_prev <= cts_n_s;
      second_interrupt_status <= (second_interrupt_status & ~isr_clr) |
                                 isr_set;
      // Masked sources still flag, but never reach the pin.
      irq_n <= ~|(second_interrupt_status & ~second_interrupt_mask);
    end
  end

  // The buffer itself needs no reset; the pointers define its contents.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= wb_dat_i[7:0];
    end
  end

  // Transmit engine and buffer pointers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      frm_ptr    <= '0;
      count      <= '0;
      sent       <= '0;
      start_kept <= 1'b0;
      frame_open <= 1'b0;
      tx_req     <= 1'b0;
      tx_state   <= smh_pkg::SMH_TX_IDLE;
      tx_shift   <= '1;
      tx_bits    <= '0;
      ev_xmr     <= 1'b0;
      ev_all_sent_irq    <= 1'b0;
      ev_xpr     <= 1'b0;
    end else if (cmd_xres || !power_up) begin
      wr_ptr     <= '0;
      rd_ptr     <= '0;
      count      <= '0;
      sent       <= '0;
      start_kept <= 1'b0;
      frame_open <= 1'b0;
      tx_req     <= 1'b0;
      tx_state   <= smh_pkg::SMH_TX_IDLE;
      tx_shift   <= '1;
      tx_bits    <= '0;
      ev_xmr     <= 1'b0;
      ev_all_sent_irq    <= 1'b0;
      ev_xpr     <= 1'b0;
    end else begin
      ev_xmr  <= 1'b0;
      ev_all_sent_irq <= 1'b0;
      ev_xpr  <= 1'b0;
      count   <= cnt_push;
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (cmd_xmit && cnt_push != '0) begin
        tx_req <= 1'b1;
      end
      unique case (tx_state)
        smh_pkg::SMH_TX_IDLE: begin
          // A character starts only on grant; async resumes here too.
          if (tx_req && cts_ok && bit_tick && count != '0) begin
            if (!frame_open) begin
              frm_ptr    <= rd_ptr;
              start_kept <= 1'b1;
              frame_open <= 1'b1;
            end
            tx_shift <= {1'b1, mem[rd_ptr], 1'b0};
            tx_bits  <= 4'hA;
            tx_state <= smh_pkg::SMH_TX_SHIFT;
          end
        end
        smh_pkg::SMH_TX_SHIFT: begin
          if (bit_tick) begin
            // Async keeps shifting through a lost grant.
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_bits  <= tx_bits - 1'b1;
            if (tx_bits == 4'h1) begin
              tx_state <= smh_pkg::SMH_TX_IDLE;
              rd_ptr   <= rd_ptr + 1'b1;
              count    <= cnt_push - 1'b1;
              sent     <= sent + 1'b1;
              if (start_kept && sent + 1'b1 == POOL) begin
                start_kept <= 1'b0;
                ev_xpr     <= 1'b1;
              end
              if (cnt_push == (AW+1)'(1)) begin
                tx_req     <= 1'b0;
                frame_open <= 1'b0;
                start_kept <= 1'b0;
                sent       <= '0;
                ev_all_sent_irq    <= 1'b1;
              end
            end
          end
        end
      endcase
      // Grant lost inside a frame aborts it, also in a gap between bytes.
      if (frame_mode && frame_open && !cts_ok) begin
        tx_state   <= smh_pkg::SMH_TX_IDLE;
        tx_shift   <= '1;
        frame_open <= 1'b0;
        sent       <= '0;
        if (start_kept) begin
          rd_ptr <= frm_ptr;
          count  <= cnt_push + sent;
        end else begin
          // Pool gone: the frame cannot be rebuilt here.
          wr_ptr     <= '0;
          rd_ptr     <= '0;
          count      <= '0;
          start_kept <= 1'b0;
          tx_req     <= 1'b0;
          ev_xmr     <= 1'b1;
        end
      end
    end
  end

  // Receive shifter.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= smh_pkg::SMH_RX_IDLE;
      rx_sh    <= '0;
      rx_bits  <= '0;
      rx_data  <= '0;
      rx_valid <= 1'b0;
    end else begin
      if (rd && hit(wb_adr, `SMH_ADR_RXD)) begin
        rx_valid <= 1'b0;
      end
      unique case (rx_state)
        smh_pkg::SMH_RX_IDLE: begin
          if (bit_tick && rx_allow && !rx_line) begin
            rx_state <= smh_pkg::SMH_RX_SHIFT;
            rx_bits  <= 4'h9;
          end
        end
        smh_pkg::SMH_RX_SHIFT: begin
          // Carrier is not looked at once a character has begun.
          if (bit_tick) begin
            rx_bits <= rx_bits - 1'b1;
            if (rx_bits == 4'h1) begin
              rx_data  <= rx_sh;
              rx_valid <= 1'b1;
              rx_state <= smh_pkg::SMH_RX_IDLE;
            end else begin
              rx_sh <= {rx_line, rx_sh[7:1]};
            end
          end
        end
      endcase
    end
  end

  // Request output selection.
  always_comb begin
    next_rts_n = !tx_req;
    if (mode_reg[`SMH_MODE_SWC]) begin
      next_rts_n = !mode_reg[`SMH_MODE_SWL];
    end
    if (bus_cfg && rts_sel == 2'h1 &&
        (clk_mode <= 3'h1 || clk_mode == 3'h4)) begin
      next_rts_n = !tx_mark_d;
    end
    if (bus_cfg && clk_mode <= 3'h1) begin
      if (rts_sel == 2'h3) begin
        next_rts_n = !rx_active;
      end else if (rts_sel == 2'h2) begin
        next_rts_n = 1'b1;
      end
    end
    if (!power_up) begin
      next_rts_n = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n     <= 1'b1;
      txd       <= 1'b1;
      tx_mark_d <= 1'b0;
    end else begin
      rts_n <= next_rts_n;
      txd   <= tx_line ^ invert;
      if (bit_tick) begin
        tx_mark_d <= tx_state == smh_pkg::SMH_TX_SHIFT;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/smh_modem_ctrl_assertions.sv]
// Checker for the modem handshake block: bus answer, line timing, irq.
// Assumes nothing of clear-to-send; line checks wait for it to be steady 6 or 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module smh_modem_ctrl_assertions #(
  parameter int DEPTH        = 8,
  parameter int CLKS_PER_BIT = 16
) (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // Wishbone
  input wire logic        wb_cyc,
  input wire logic        wb_stb,
  input wire logic        wb_we,
  input wire logic [7:0]  wb_adr,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack,
  // Modem lines
  input wire logic        cts_n,
  input wire logic        cd,
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        rts_n,
  input wire logic        irq_n
);
  localparam int IDLE = 10 * CLKS_PER_BIT;
  int lo_run;
  int hi_run;
  int cts_lo;
  int cts_hi;
  // The high run saturates so a long idle line cannot wrap it; the low run does not.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_run <= 0;
      hi_run <= 0;
    end else begin
      lo_run <= txd ? 0 : lo_run + 1;
      hi_run <= !txd ? 0 : (hi_run < IDLE ? hi_run + 1 : hi_run);
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cts_lo <= 0;
      cts_hi <= 0;
    end else begin
      cts_lo <= cts_n ? 0 : (cts_lo < 15 ? cts_lo + 1 : cts_lo);
      cts_hi <= !cts_n ? 0 : (cts_hi < 15 ? cts_hi + 1 : cts_hi);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_req; wb_cyc && wb_stb && !wb_ack; endsequence
  sequence s_ans; wb_ack ##1 !wb_ack; endsequence
  property p_ack_lat; s_req |=> s_ans; endproperty
  property p_ack_pulse; wb_ack |=> !wb_ack; endproperty
  property p_ack_cause; $rose(wb_ack) |-> $past(wb_cyc && wb_stb); endproperty
  property p_rd_hi; wb_ack && !wb_we |-> wb_dat_o[31:8] == 24'h000000;
  endproperty
  property p_reset_out;
    $rose(rst_n) |-> txd && rts_n && irq_n && !wb_ack;
  endproperty
  property p_idle_hold; hi_run >= IDLE && cts_hi >= 6 |=> txd; endproperty
  property p_bit_len;
    $rose(txd) && cts_lo >= 8 |-> lo_run % CLKS_PER_BIT == 0;
  endproperty
  property p_irq_rise;
    $rose(irq_n) |-> $past(wb_ack && wb_we) || $past(wb_ack && wb_we, 2);
  endproperty
  a_ack_lat: assert property (p_ack_lat)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  a_rd_hi: assert property (p_rd_hi)
    else $error("read data upper bits set");
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not idle after reset");
  a_idle_hold: assert property (p_idle_hold)
    else $error("txd left idle without grant");
  a_bit_len: assert property (p_bit_len)
    else $error("low run not whole bit periods");
  a_irq_rise: assert property (p_irq_rise)
    else $error("irq released without a register write");
endmodule
bind smh_modem_ctrl smh_modem_ctrl_assertions #(
  .DEPTH(DEPTH),
  .CLKS_PER_BIT(CLKS_PER_BIT)
) u_chk (
  .sys_clk, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_dat_i,
  .wb_sel, .wb_dat_o, .wb_ack, .cts_n, .cd, .rxd, .txd, .rts_n, .irq_n
);
`default_nettype wire

// [verification/smh_modem.sv]
// Modem model: grants clear-to-send on request, captures and sends chars.
// Assumes 10-bit characters, LSB first, B clock cycles per bit.
`timescale 1ns/1ps
`default_nettype none
module smh_modem #(
  parameter int B = 4
) (
  // Clock and controls
  input  wire logic       sys_clk,
  input  wire logic       allow,
  input  wire logic       slow,
  input  wire logic       send,
  input  wire logic [7:0] sbyte,
  // Modem lines
  input  wire logic       rts_n,
  input  wire logic       txd,
  output logic            cts_n,
  output logic            rxd,
  // Captured characters
  output int              got_n
);
  logic [7:0] rxq [$];
  logic [7:0] b;
  int         wait_c = 0;
  initial cts_n = 1'b1;
  initial rxd = 1'b1;
  initial got_n = 0;
  // Grant follows a request only, promptly or after a long wait.
  always @(posedge sys_clk) begin
    if (rts_n || !allow) begin
      wait_c <= 0;
      cts_n  <= 1'b1;
    end else begin
      wait_c <= wait_c + 1;
      if (wait_c >= (slow ? 8 : 0)) cts_n <= 1'b0;
    end
  end
  always begin
    @(negedge txd);
    repeat (B / 2) @(posedge sys_clk);
    if (txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (B) @(posedge sys_clk);
        b[i] = txd;
      end
      repeat (B) @(posedge sys_clk);
      rxq.push_back(b);
      got_n++;
    end
  end
  // The receive line rests high, as under a pull-up.
  always @(posedge send) begin
    rxd <= 1'b0;
    repeat (B) @(posedge sys_clk);
    for (int k = 0; k < 8; k++) begin
      rxd <= sbyte[k];
      repeat (B) @(posedge sys_clk);
    end
    rxd <= 1'b1;
  end
endmodule
`default_nettype wire

// [verification/smh_modem_ctrl_tb.sv]
// Bench for the modem handshake block with a modem model on its lines.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none
`include "smh_params.svh"
module smh_modem_ctrl_tb;
  localparam int B = 4;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [3:0]  wb_sel = 4'hF;
  logic [31:0] wb_dat_o;
  logic        wb_ack, cts_n, rxd, txd, rts_n, irq_n;
  logic        cd = 1'b0;
  logic        allow = 1'b0;
  logic        send = 1'b0;
  logic [7:0]  sbyte = 8'h00;
  logic [7:0]  q;
  int          got_n, base;
  int          error_cnt = 0;
  int          n_tests = 0;
  always #5 sys_clk = ~sys_clk;
  smh_modem_ctrl #(.DEPTH(8), .CLKS_PER_BIT(B)) uut (
    .sys_clk, .rst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_dat_i,
    .wb_sel, .wb_dat_o, .wb_ack, .cts_n, .cd, .rxd, .txd, .rts_n, .irq_n);
  smh_modem #(.B(B)) mdm (.sys_clk, .allow, .slow(1'b1), .send, .sbyte,
    .rts_n, .txd, .cts_n, .rxd, .got_n);
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, d);
    @(posedge sys_clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= w;
    wb_adr   <= a;
    wb_dat_i <= {24'h000000, d};
    do @(posedge sys_clk); while (wb_ack !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    wb(1'b1, a, d);
  endtask
  task automatic rchk(input logic [7:0] a, e, input string nm);
    wb(1'b0, a, 8'h00);
    chk(nm, q, e);
  endtask
  task automatic snd(input logic [7:0] v);
    sbyte <= v;
    send  <= 1'b1;
    cyc(1);
    send  <= 1'b0;
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_reset;
    rchk(`SMH_ADR_CFG, 8'h00, "cfg");
    rchk(`SMH_ADR_CHANNEL_CONFIGURATION_TWO, 8'h00, "channel_configuration_two");
    rchk(`SMH_ADR_TRANSMIT_BYTE_COUNT_HIGH, 8'h00, "transmit_byte_count_high");
    rchk(`SMH_ADR_IMR, 8'hFF, "imr");
    rchk(`SMH_ADR_MODE, 8'h00, "mode");
    wr(8'h3C, 8'hFF);
    rchk(8'h3C, 8'h00, "unmapped");
  endtask
  task automatic t_swrts;
    wr(`SMH_ADR_CFG, 8'h03);
    allow <= 1'b1;
    wr(`SMH_ADR_MODE, 8'h06);
    cyc(16);
    chk("rts sw low", rts_n, 1'b0);
    rchk(`SMH_ADR_ISR, 8'h01, "cts change");
    chk("irq masked", irq_n, 1'b1);
    wr(`SMH_ADR_IMR, 8'hFE);
    cyc(3);
    chk("irq on", irq_n, 1'b0);
    wr(`SMH_ADR_ISR, 8'h01);
    cyc(3);
    chk("irq cleared", irq_n, 1'b1);
    wr(`SMH_ADR_MODE, 8'h02);
    cyc(3);
    chk("rts sw high", rts_n, 1'b1);
    wr(`SMH_ADR_IMR, 8'hFF);
    wr(`SMH_ADR_MODE, 8'h00);
    wr(`SMH_ADR_ISR, 8'hFF);
  endtask
  task automatic t_async;
    base = got_n;
    wr(`SMH_ADR_TXD, 8'h81);
    wr(`SMH_ADR_TXD, 8'h7E);
    wr(`SMH_ADR_CMD, 8'h01);
    cyc(3);
    chk("rts request", rts_n, 1'b0);
    wait (txd === 1'b0);
    cyc(2 * B);
    allow <= 1'b0;
    wait (got_n == base + 1);
    chk("char done", mdm.rxq[base], 8'h81);
    cyc(15 * B);
    chk("held idle", got_n, base + 1);
    allow <= 1'b1;
    wait (got_n == base + 2);
    chk("next char", mdm.rxq[base+1], 8'h7E);
    cyc(3 * B);
    chk("rts released", rts_n, 1'b1);
    rchk(`SMH_ADR_ISR, 8'h05, "all sent");
    wr(`SMH_ADR_ISR, 8'hFF);
  endtask
  task automatic t_abort;
    wr(`SMH_ADR_CFG, 8'h01);
    wr(`SMH_ADR_TXD, 8'h11);
    wr(`SMH_ADR_TXD, 8'h22);
    wr(`SMH_ADR_CMD, 8'h01);
    wait (txd === 1'b0);
    cyc(2 * B);
    allow <= 1'b0;
    cyc(8);
    chk("abort idle", txd, 1'b1);
    cyc(12 * B);
    base = got_n;
    allow <= 1'b1;
    wait (got_n == base + 2);
    chk("resend first", mdm.rxq[base], 8'h11);
    chk("resend second", mdm.rxq[base+1], 8'h22);
    cyc(3 * B);
    wr(`SMH_ADR_ISR, 8'hFF);
  endtask
  task automatic t_repeat;
    base = got_n;
    for (int i = 1; i <= 5; i++) wr(`SMH_ADR_TXD, i[7:0]);
    wr(`SMH_ADR_CMD, 8'h01);
    wait (got_n == base + 4);
    allow <= 1'b0;
    cyc(20);
    chk("rts dropped", rts_n, 1'b1);
    wb(1'b0, `SMH_ADR_ISR, 8'h00);
    chk("repeat flag", q & 8'h02, 8'h02);
    allow <= 1'b1;
    cyc(4 * B);
    chk("nothing left", rts_n, 1'b1);
    wr(`SMH_ADR_ISR, 8'hFF);
  endtask
  task automatic t_rx;
    wr(`SMH_ADR_CFG, 8'h03);
    wr(`SMH_ADR_TRANSMIT_BYTE_COUNT_HIGH, 8'h80);
    wr(`SMH_ADR_MODE, 8'h08);
    snd(8'h3C);
    cyc(12 * B);
    wb(1'b0, `SMH_ADR_STAT, 8'h00);
    chk("no carrier", q[6], 1'b0);
    cd <= 1'b1;
    snd(8'hC3);
    cyc(12 * B);
    rchk(`SMH_ADR_RXD, 8'hC3, "carrier rx");
    snd(8'h96);
    cyc(3 * B);
    cd <= 1'b0;
    cyc(10 * B);
    rchk(`SMH_ADR_RXD, 8'h96, "carrier lost");
    wr(`SMH_ADR_CFG, 8'h13);
    snd(8'h69);
    cyc(12 * B);
    rchk(`SMH_ADR_RXD, 8'h69, "mode one");
    wr(`SMH_ADR_CFG, 8'h03);
    wr(`SMH_ADR_TRANSMIT_BYTE_COUNT_HIGH, 8'h00);
    wr(`SMH_ADR_MODE, 8'h09);
    wr(`SMH_ADR_TXD, 8'h5A);
    wr(`SMH_ADR_CMD, 8'h01);
    cyc(16 * B);
    rchk(`SMH_ADR_RXD, 8'h5A, "loopback");
  endtask
  task automatic t_rts_sel;
    wr(`SMH_ADR_CFG, 8'h09);
    wr(`SMH_ADR_CHANNEL_CONFIGURATION_TWO, 8'h80);
    wr(`SMH_ADR_MODE, 8'h06);
    cyc(4);
    chk("sel off", rts_n, 1'b1);
    wr(`SMH_ADR_MODE, 8'h08);
    wr(`SMH_ADR_CHANNEL_CONFIGURATION_TWO, 8'hC0);
    snd(8'hE7);
    cyc(3 * B);
    chk("sel rx", rts_n, 1'b0);
    cyc(10 * B);
    chk("sel rx end", rts_n, 1'b1);
    wr(`SMH_ADR_CFG, 8'h29);
    snd(8'hE7);
    cyc(3 * B);
    chk("sel mode two", rts_n, 1'b1);
    cyc(10 * B);
    wr(`SMH_ADR_CFG, 8'h09);
    wr(`SMH_ADR_CHANNEL_CONFIGURATION_TWO, 8'h40);
    wr(`SMH_ADR_TXD, 8'hA5);
    wr(`SMH_ADR_CMD, 8'h01);
    cyc(8);
    chk("bus mark idle", rts_n, 1'b1);
    wr(`SMH_ADR_CMD, 8'h02);
  endtask
  initial begin
    cyc(5);
    rst_n <= 1'b1;
    cyc(2);
    t_reset();
    t_swrts();
    t_async();
    t_abort();
    t_repeat();
    t_rx();
    t_rts_sel();
    conclude();
  end
  // The run needs well under a tenth of this span.
  initial begin
    #500000;
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
